// File: core_model.sv
`timescale 1ns/1ns
module core_model (
    input wire clock_i,
    input wire nrst_i,
    input wire int_req_i,
    input wire take_i,
    input wire ret_i,
    input wire [3:0] insn_len_i,
    output wire call_o,
    output reg rets_o,
    output reg insn_o
);
    reg [3:0] cnt_r;
    // prompt call
    // Taking in the request cycle is the fastest core; take_i low stalls it.
    assign call_o = int_req_i & take_i;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rets_o <= 1'b0;
            insn_o <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            rets_o <= ret_i;
            insn_o <= cnt_r == 4'h1;
            if (ret_i) begin
                cnt_r <= insn_len_i;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule // core_model

// File: irq_ctrl_checker.sv
`timescale 1ns/1ns
module irq_ctrl_checker (
    input wire clock_i,
    input wire nrst_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    input wire [7:0] timer_control_reg_i,
    input wire ext0_pending_o,
    input wire core_int_req_o,
    input wire [15:0] core_vector_o,
    input wire [4:0] core_source_o,
    input wire core_level_high_o,
    input wire core_vector_call_i,
    input wire [1:0] active_levels_o
);
    reg ge_r;
    wire sel_en;
    assign sel_en = sfr_addr_i == 8'ha8;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // The decode lags a write by one edge, so the check waits two.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ge_r <= 1'b0;
        end else if (sfr_wr_i && sel_en) begin
            ge_r <= sfr_wdata_i[7];
        end
    end
    a_unused_bit_zero: assert property (sfr_rd_i && sel_en |=> !sfr_rdata_o[6])
        else $error("enable bit 6 read as one");
    a_prio_top_zero: assert property (sfr_rd_i && sfr_addr_i == 8'hb8 |=> sfr_rdata_o[7:6] == 2'b00)
        else $error("priority bits 7:6 not zero");
    a_vector_form: assert property (core_int_req_o |-> core_vector_o == {8'h00, core_source_o, 3'b011})
        else $error("vector not spaced by eight");
    a_call_gap: assert property (core_vector_call_i |=> !core_int_req_o [*4])
        else $error("request during vector call");
    a_high_no_preempt: assert property (active_levels_o[1] |-> !core_int_req_o)
        else $error("request while high level active");
    a_low_only_high: assert property (active_levels_o[0] && core_int_req_o |-> core_level_high_o)
        else $error("low request while low level active");
    a_global_off: assert property (!ge_r && $past(!ge_r) && $past(!ge_r, 2) |-> !core_int_req_o)
        else $error("request with global enable off");
    a_edge_clear: assert property (core_vector_call_i && core_source_o == 5'h00 && timer_control_reg_i[0]
        |-> ##[1:3] !ext0_pending_o)
        else $error("edge flag not cleared by call");
    c_high_call: cover property (core_vector_call_i && core_level_high_o);
    c_both_active: cover property (active_levels_o == 2'b11);
    c_ext0_call: cover property (core_vector_call_i && core_source_o == 5'h00);
endmodule // irq_ctrl_checker

bind vectored_two_level_interrupt_ctrl irq_ctrl_checker chk_u (.*);

// File: irq_ctrl_consts.vh
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// Register addresses on the special function register port.
`define ADDR_SOURCE_ENABLE_MASK 8'ha8
`define ADDR_PRIORITY_LEVEL_SELECT 8'hb8

// Reset values.
`define RST_SOURCE_ENABLE_MASK 8'h00
`define RST_PRIORITY_LEVEL_SELECT 8'h00

// Field positions in the enable register.
`define BIT_GLOBAL_ENABLE 7
`define BIT_ENABLE_UNUSED 6
// Writable bits of each register; the rest read as zero.
`define MASK_SOURCE_ENABLE 8'hbf
`define MASK_PRIORITY_LEVEL 8'h3f

// Trigger-type field positions in the timer control register.
`define BIT_EXT0_TRIGGER_TYPE 0
`define BIT_EXT1_TRIGGER_TYPE 2

// Source numbering and vectors.
`define NUM_SOURCES 22
`define SRC_EXT0 0
`define SRC_EXT1 2
`define SRC_UART 4
`define SRC_TIMER2 5
`define SRC_COUNTER_ARRAY 9
`define SRC_EXT4 16
`define RESET_VECTOR 16'h0000
`define VECTOR_LOW_BITS 3'h3

// Core call timing in clock cycles.
`define DETECT_CYCLES 1
`define VECTOR_CALL_CYCLES 4

`endif

// File: vectored_two_level_interrupt_ctrl.v
`timescale 1ns/1ns
// Contract
// - Ext 0/1 active low, trigger-type bit selects mode.
// - Edge-mode ext pending clears on vector call.
// - Level-mode ext pending follows the pin.
// - Ext 4-7 edge only, flags bits 4-7.
// - Reset vector zero; sources eight bytes apart.
// - Same level: lowest source number wins.
// - UART requests on receive or transmit done.
// - Counter array: overflow or any match flag.
// - Timer 2: overflow or external flag.
// - Comparator edges are separate sources.
// - High preempts low; high never preempted.
// - Per-source priority bit, reset to low.
// - High level served before low level.
// - Sample every cycle; five-cycle fastest response.
// - After return, one instruction before next call.
// - Equal or lower level waits for return.
// - Global enable overrides all individual masks.
// - Enable bit 6 reads zero, ignores writes.
// - Enable bits 0-5 mask sources 0-5.
// - Priority bits 7-6 read zero.
// - Priority bits 0-5 follow enable order.
// - Pending flags set regardless of enable.
// - Flag still set after return re-requests.
// - Software-set pending flag requests like hardware.
`include "irq_ctrl_consts.vh"

module vectored_two_level_interrupt_ctrl (
    input wire clock_i,
    input wire nrst_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    output reg [7:0] sfr_rdata_o,
    input wire [7:0] timer_control_reg_i,
    input wire ext0_input_n_i,
    input wire ext1_input_n_i,
    input wire [3:0] ext47_input_n_i,
    input wire [5:0] ext_pending_set_i,
    input wire [5:0] ext_pending_clr_i,
    output reg ext0_pending_o,
    output reg ext1_pending_o,
    output reg [7:0] port_edge_flags_o,
    input wire [21:0] periph_pending_i,
    input wire uart_rx_done_i,
    input wire uart_tx_done_i,
    input wire timer2_overflow_flag_i,
    input wire timer2_external_flag_i,
    input wire counter_array_overflow_i,
    input wire [4:0] module_match_flag_i,
    input wire [15:0] ext_enable_i,
    input wire [15:0] ext_priority_i,
    output reg core_int_req_o,
    output reg [15:0] core_vector_o,
    output reg [4:0] core_source_o,
    output reg core_level_high_o,
    input wire core_vector_call_i,
    input wire core_return_from_service_i,
    input wire core_insn_done_i,
    output wire [1:0] active_levels_o,
    output wire [15:0] reset_vector_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_CALL = 3'b100;

    reg [7:0] source_enable_mask_r;
    reg [7:0] priority_level_select_r;
    reg [5:0] sync1_r;
    reg [5:0] sync2_r;
    reg [5:0] sync3_r;
    reg [5:0] pin_low_r;
    reg [5:0] edge_pend_r;
    reg [5:0] edge_pend_nxt;
    reg active_low_r;
    reg active_high_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] call_cnt_r;
    reg [21:0] pending;
    reg [21:0] enabled;
    reg [21:0] prio_high;
    reg [21:0] elig_high;
    reg [21:0] elig_low;
    reg [4:0] win_src;
    reg win_found;
    reg win_high;
    reg [5:0] edge_seen;
    wire ext0_edge_mode;
    wire ext1_edge_mode;
    wire [5:0] pins_n;
    integer i;
    integer j;
    integer k;

    assign pins_n = {ext47_input_n_i, ext1_input_n_i, ext0_input_n_i};
    assign ext0_edge_mode = timer_control_reg_i[`BIT_EXT0_TRIGGER_TYPE];
    assign ext1_edge_mode = timer_control_reg_i[`BIT_EXT1_TRIGGER_TYPE];
    assign reset_vector_o = `RESET_VECTOR;
    assign active_levels_o = {active_high_r, active_low_r};

    // Pins are asynchronous: a level counts once the second and third stages agree.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
            sync3_r <= 6'h3f;
            pin_low_r <= 6'h00;
        end else begin
            sync1_r <= pins_n;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (i = 0; i < 6; i = i + 1) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    pin_low_r[i] <= ~sync3_r[i];
                end
            end
        end
    end

    // Edge flags: set wins over any clear in the same cycle.
    always @* begin
        edge_seen = 6'h00;
        edge_pend_nxt = edge_pend_r;
        for (j = 0; j < 6; j = j + 1) begin
            if (sync2_r[j] == sync3_r[j] && !sync3_r[j] && !pin_low_r[j]) begin
                edge_seen[j] = 1'b1;
            end
        end
        edge_pend_nxt = edge_pend_nxt & ~ext_pending_clr_i;
        if (state_r == ST_CALL && call_cnt_r == 3'h0) begin
            if (core_source_o == `SRC_EXT0 && ext0_edge_mode) begin
                edge_pend_nxt[0] = 1'b0;
            end
            if (core_source_o == `SRC_EXT1 && ext1_edge_mode) begin
                edge_pend_nxt[1] = 1'b0;
            end
            for (j = 2; j < 6; j = j + 1) begin
                if (core_source_o == `SRC_EXT4 + j - 2) begin
                    edge_pend_nxt[j] = 1'b0;
                end
            end
        end
        edge_pend_nxt = edge_pend_nxt | edge_seen | ext_pending_set_i;
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_pend_r <= 6'h00;
        end else begin
            edge_pend_r <= edge_pend_nxt;
        end
    end

    // Flags shown to software are registered copies.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext0_pending_o <= 1'b0;
            ext1_pending_o <= 1'b0;
            port_edge_flags_o <= 8'h00;
        end else begin
            ext0_pending_o <= ext0_edge_mode ? edge_pend_nxt[0] : pin_low_r[0];
            ext1_pending_o <= ext1_edge_mode ? edge_pend_nxt[1] : pin_low_r[1];
            port_edge_flags_o <= {edge_pend_nxt[5:2], 4'h0};
        end
    end

    // Register port; unused bits are held at zero.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            source_enable_mask_r <= `RST_SOURCE_ENABLE_MASK;
            priority_level_select_r <= `RST_PRIORITY_LEVEL_SELECT;
            sfr_rdata_o <= 8'h00;
        end else begin
            if (sfr_wr_i && sfr_addr_i == `ADDR_SOURCE_ENABLE_MASK) begin
                source_enable_mask_r <= sfr_wdata_i & `MASK_SOURCE_ENABLE;
            end else if (sfr_wr_i && sfr_addr_i == `ADDR_PRIORITY_LEVEL_SELECT) begin
                priority_level_select_r <= sfr_wdata_i & `MASK_PRIORITY_LEVEL;
            end
            if (sfr_rd_i && sfr_addr_i == `ADDR_SOURCE_ENABLE_MASK) begin
                sfr_rdata_o <= source_enable_mask_r;
            end else if (sfr_rd_i && sfr_addr_i == `ADDR_PRIORITY_LEVEL_SELECT) begin
                sfr_rdata_o <= priority_level_select_r;
            end else if (sfr_rd_i) begin
                sfr_rdata_o <= 8'h00;
            end
        end
    end

    // Source collection and masking.
    always @* begin
        pending = periph_pending_i;
        pending[`SRC_EXT0] = ext0_edge_mode ? edge_pend_r[0] : pin_low_r[0];
        pending[`SRC_EXT1] = ext1_edge_mode ? edge_pend_r[1] : pin_low_r[1];
        pending[`SRC_UART] = uart_rx_done_i | uart_tx_done_i;
        pending[`SRC_TIMER2] = timer2_overflow_flag_i | timer2_external_flag_i;
        pending[`SRC_COUNTER_ARRAY] = counter_array_overflow_i | (|module_match_flag_i);
        pending[`SRC_EXT4 + 3:`SRC_EXT4] = edge_pend_r[5:2];
        enabled = {ext_enable_i, source_enable_mask_r[5:0]};
        if (!source_enable_mask_r[`BIT_GLOBAL_ENABLE]) begin
            enabled = 22'h000000;
        end
        prio_high = {ext_priority_i, priority_level_select_r[5:0]};
        elig_high = pending & enabled & prio_high;
        elig_low = pending & enabled & ~prio_high;
        if (active_high_r) begin
            elig_high = 22'h000000;
            elig_low = 22'h000000;
        end else if (active_low_r) begin
            elig_low = 22'h000000;
        end
        win_src = 5'h00;
        win_found = 1'b0;
        win_high = 1'b0;
        for (k = `NUM_SOURCES - 1; k >= 0; k = k - 1) begin
            if (elig_low[k]) begin
                win_src = k[4:0];
                win_found = 1'b1;
            end
        end
        for (k = `NUM_SOURCES - 1; k >= 0; k = k - 1) begin
            if (elig_high[k]) begin
                win_src = k[4:0];
                win_found = 1'b1;
                win_high = 1'b1;
            end
        end
    end

    // Request sequencing around calls and returns.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (core_int_req_o && core_vector_call_i) begin
                    state_nxt = ST_CALL;
                end
            end
            ST_CALL: begin
                if (call_cnt_r == `VECTOR_CALL_CYCLES - 1) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (core_insn_done_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (core_return_from_service_i) begin
            state_nxt = ST_HOLD;
        end
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            call_cnt_r <= 3'h0;
            active_low_r <= 1'b0;
            active_high_r <= 1'b0;
            core_int_req_o <= 1'b0;
            core_vector_o <= `RESET_VECTOR;
            core_source_o <= 5'h00;
            core_level_high_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            call_cnt_r <= (state_r == ST_CALL) ? call_cnt_r + 3'h1 : 3'h0;
            // Mark on call, clear highest on return.
            if (state_r == ST_IDLE && core_int_req_o && core_vector_call_i) begin
                if (core_level_high_o) begin
                    active_high_r <= 1'b1;
                end else begin
                    active_low_r <= 1'b1;
                end
            end else if (core_return_from_service_i) begin
                if (active_high_r) begin
                    active_high_r <= 1'b0;
                end else begin
                    active_low_r <= 1'b0;
                end
            end
            // One detect cycle, decoded every cycle.
            if (state_nxt == ST_IDLE && state_r == ST_IDLE && !core_vector_call_i) begin
                core_int_req_o <= win_found;
                core_source_o <= win_src;
                core_level_high_o <= win_high;
                core_vector_o <= {8'h00, win_src, `VECTOR_LOW_BITS};
            end else begin
                core_int_req_o <= 1'b0;
            end
        end
    end

endmodule // vectored_two_level_interrupt_ctrl

// File: vectored_two_level_interrupt_ctrl_tb_top.sv
`timescale 1ns/1ns
module vectored_two_level_interrupt_ctrl_tb_top;
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] pri;
        logic [15:0] xen;
        logic [15:0] xpri;
        logic [21:0] pend;
        logic [2:0] lvl;
        logic [5:0] src;
        logic hi;
    } row_t;
    row_t rows [0:9];
    reg clock_i = 1'b0, nrst_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, ret = 1'b0;
    reg [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, timer_control_reg_i = 8'h00, d;
    reg ext0_input_n_i = 1'b1, ext1_input_n_i = 1'b1, uart_rx_done_i = 1'b0, got;
    reg uart_tx_done_i = 1'b0, timer2_overflow_flag_i = 1'b0, timer2_external_flag_i = 1'b0;
    reg counter_array_overflow_i = 1'b0;
    reg [3:0] ext47_input_n_i = 4'hf;
    reg [5:0] ext_pending_set_i = 6'h00, ext_pending_clr_i = 6'h00;
    reg [21:0] periph_pending_i = 22'h0;
    reg [4:0] module_match_flag_i = 5'h00;
    reg [15:0] ext_enable_i = 16'h0000, ext_priority_i = 16'h0000;
    wire core_vector_call_i, core_return_from_service_i, core_insn_done_i;
    wire ext0_pending_o, ext1_pending_o, core_int_req_o, core_level_high_o;
    wire [7:0] sfr_rdata_o, port_edge_flags_o;
    wire [15:0] core_vector_o, reset_vector_o;
    wire [4:0] core_source_o;
    wire [1:0] active_levels_o;
    integer fails = 0, compares = 0, i, n;
    vectored_two_level_interrupt_ctrl dut_u (.*);
    core_model core_u (.clock_i(clock_i), .nrst_i(nrst_i), .int_req_i(core_int_req_o),
        .take_i(1'b1), .ret_i(ret), .insn_len_i(4'h3), .call_o(core_vector_call_i),
        .rets_o(core_return_from_service_i), .insn_o(core_insn_done_i));
    always #50 clock_i = ~clock_i;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input integer c);
        repeat (c) @(negedge clock_i);
    endtask
    task wr_reg(input [7:0] a, input [7:0] v);
        @(negedge clock_i);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        @(negedge clock_i);
        sfr_wr_i = 1'b0;
    endtask
    task rd_reg(input [7:0] a);
        @(negedge clock_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clock_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask
    task see(input [5:0] s, input h);
        got = 1'b0;
        for (i = 0; i < 20 && !got; i = i + 1) begin
            @(negedge clock_i);
            got = core_int_req_o === 1'b1;
        end
        chk(got, s != 6'h3f);
        if (s != 6'h3f) begin
            chk(core_source_o, s);
            chk(core_vector_o, 16'h0003 + 16'h0008 * s);
            chk(core_level_high_o, h);
        end
    endtask
    task serve;
        @(negedge clock_i);
        ret = 1'b1;
        @(negedge clock_i);
        ret = 1'b0;
        tick(2);
        chk(core_int_req_o, 1'b0);
    endtask
    task final_report;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        final_report;
    end
    initial begin
        rows = '{'{8'h82, 8'h00, 16'h0, 16'h0, 22'h2, 3'h0, 6'h01, 1'b0},
            '{8'h8a, 8'h00, 16'h0, 16'h0, 22'ha, 3'h0, 6'h01, 1'b0},
            '{8'h8a, 8'h08, 16'h0, 16'h0, 22'ha, 3'h0, 6'h03, 1'b1},
            '{8'h80, 8'h00, 16'h8000, 16'h0, 22'h200000, 3'h0, 6'h15, 1'b0},
            '{8'h80, 8'h00, 16'h0030, 16'h0020, 22'hc00, 3'h0, 6'h0b, 1'b1},
            '{8'h90, 8'h00, 16'h0, 16'h0, 22'h0, 3'h4, 6'h04, 1'b0},
            '{8'ha0, 8'h00, 16'h0, 16'h0, 22'h0, 3'h2, 6'h05, 1'b0},
            '{8'h80, 8'h00, 16'h0008, 16'h0, 22'h0, 3'h1, 6'h09, 1'b0},
            '{8'h02, 8'h00, 16'h0, 16'h0, 22'h2, 3'h0, 6'h3f, 1'b0},
            '{8'h80, 8'h00, 16'h0001, 16'h0, 22'h42, 3'h0, 6'h06, 1'b0}};
        tick(16);
        nrst_i = 1'b1;
        tick(4);
        for (n = 0; n < 10; n = n + 1) begin
            wr_reg(8'ha8, rows[n].en);
            wr_reg(8'hb8, rows[n].pri);
            ext_enable_i = rows[n].xen;
            ext_priority_i = rows[n].xpri;
            periph_pending_i = rows[n].pend;
            {uart_tx_done_i, timer2_external_flag_i, module_match_flag_i[2]} = rows[n].lvl;
            see(rows[n].src, rows[n].hi);
            periph_pending_i = 22'h0;
            {uart_tx_done_i, timer2_external_flag_i, module_match_flag_i[2]} = 3'h0;
            if (got) serve;
        end
        timer_control_reg_i = 8'h05;
        wr_reg(8'ha8, 8'h81);
        ext0_input_n_i = 1'b0;
        see(6'h00, 1'b0);
        tick(3);
        chk(ext0_pending_o, 1'b0);
        ext0_input_n_i = 1'b1;
        serve;
        wr_reg(8'ha8, 8'h00);
        timer_control_reg_i = 8'h04;
        ext0_input_n_i = 1'b0;
        tick(5);
        chk(ext0_pending_o, 1'b1);
        ext0_input_n_i = 1'b1;
        ext47_input_n_i = 4'he;
        tick(5);
        chk(ext0_pending_o, 1'b0);
        chk(port_edge_flags_o, 8'h10);
        ext_pending_clr_i = 6'h04;
        ext_pending_set_i = 6'h04;
        tick(1);
        chk(port_edge_flags_o, 8'h10);
        ext_pending_set_i = 6'h00;
        tick(1);
        ext_pending_clr_i = 6'h00;
        chk(port_edge_flags_o, 8'h00);
        wr_reg(8'ha8, 8'h84);
        ext_pending_set_i = 6'h02;
        tick(1);
        chk(ext1_pending_o, 1'b1);
        ext_pending_set_i = 6'h00;
        see(6'h02, 1'b0);
        serve;
        chk(ext1_pending_o, 1'b0);
        wr_reg(8'hb8, 8'h08);
        wr_reg(8'ha8, 8'h8a);
        periph_pending_i = 22'h2;
        see(6'h01, 1'b0);
        periph_pending_i = 22'ha;
        see(6'h03, 1'b1);
        tick(6);
        chk(active_levels_o, 2'b11);
        periph_pending_i = 22'h2;
        see(6'h3f, 1'b0);
        serve;
        tick(8);
        chk(active_levels_o, 2'b01);
        serve;
        see(6'h01, 1'b0);
        periph_pending_i = 22'h0;
        serve;
        wr_reg(8'ha8, 8'hb0);
        uart_rx_done_i = 1'b1;
        see(6'h04, 1'b0);
        uart_rx_done_i = 1'b0;
        serve;
        timer2_overflow_flag_i = 1'b1;
        see(6'h05, 1'b0);
        timer2_overflow_flag_i = 1'b0;
        serve;
        ext_enable_i = 16'h0008;
        wr_reg(8'ha8, 8'h80);
        counter_array_overflow_i = 1'b1;
        see(6'h09, 1'b0);
        counter_array_overflow_i = 1'b0;
        serve;
        wr_reg(8'ha8, 8'h84);
        ext1_input_n_i = 1'b0;
        see(6'h02, 1'b0);
        ext1_input_n_i = 1'b1;
        serve;
        // A pin still low at release would count as a fresh falling edge.
        ext47_input_n_i = 4'hf;
        nrst_i = 1'b0;
        tick(2);
        nrst_i = 1'b1;
        tick(4);
        chk(port_edge_flags_o, 8'h00);
        rd_reg(8'hb8);
        chk(d, 8'h00);
        wr_reg(8'ha8, 8'hff);
        rd_reg(8'ha8);
        chk(d, 8'hbf);
        wr_reg(8'hb8, 8'hff);
        rd_reg(8'hb8);
        chk(d, 8'h3f);
        rd_reg(8'h00);
        chk(d, 8'h00);
        chk(reset_vector_o, 16'h0000);
        final_report;
    end
endmodule // vectored_two_level_interrupt_ctrl_tb_top
